// [hw/strap_decode_pkg.sv]
// Package with constants, types and register map for the control pin mode decoder.
package strap_decode_pkg;

  // Pad comparator code of a three-level strap: {above upper threshold, above lower threshold}.
  typedef logic [1:0] pad_code_t;
  localparam pad_code_t PAD_LOW  = 2'h0;
  localparam pad_code_t PAD_MID  = 2'h1;
  localparam pad_code_t PAD_HIGH = 2'h3;

  typedef enum logic [2:0] {
    LVL_LOW  = 3'b001,
    LVL_MID  = 3'b010,
    LVL_HIGH = 3'b100
  } level_e;

  typedef enum logic [1:0] {
    MODE_PIN = 2'b01,
    MODE_EXT = 2'b10
  } ctrl_mode_e;

  // Raw pad codes of the four multi-function straps.
  typedef struct packed {
    pad_code_t shared_pin;
    pad_code_t dedicated_ext_ctrl_enable;
    pad_code_t reset_signaling_select;
    pad_code_t cal_pin;
  } strap_pins_s;

  // Decoded strap levels.
  typedef struct packed {
    level_e shared_pin;
    level_e dedicated_ext_ctrl_enable;
    level_e reset_signaling_select;
    level_e cal_pin;
  } strap_levels_s;

  localparam strap_levels_s LEVELS_RESET = '{LVL_MID, LVL_MID, LVL_MID, LVL_MID};

  // Register map, byte addresses.
  localparam logic [31:0] ADDR_FS_ADJUST = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS    = 32'h0000_0004;
  localparam int          ADDR_LSB       = 2;

  localparam logic [7:0]  FS_ADJUST_RESET = 8'h80;
  localparam logic [7:0]  FS_CODE_LOW     = 8'h00;
  localparam logic [7:0]  FS_CODE_HIGH    = 8'hFF;
  localparam logic        CAL_DELAY_SHORT = 1'b0;

  // Status register field positions.
  localparam int ST_EXT_MODE    = 0;
  localparam int ST_FS_HIGH     = 1;
  localparam int ST_FS_FROM_REG = 2;
  localparam int ST_DIFF_RESET  = 3;
  localparam int ST_RESET_NEG   = 4;
  localparam int ST_CAL_DELAY   = 5;
  localparam int ST_DES         = 6;
  localparam int ST_CHIP_SELECT = 7;
  localparam int ST_FS_CODE_LSB = 8;
  localparam int FS_W           = 8;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

endpackage : strap_decode_pkg

// [hw/adc_control_pin_mode_decode.sv]
// Mode decoder for the multi-function converter control straps, with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none

module adc_control_pin_mode_decode (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        input_clk_p,
  input  wire strap_decode_pkg::strap_pins_s straps,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic      [1:0]                  hresp,
  output logic                             sample_strobe,
  output logic                             ext_mode,
  output logic                             full_scale_high,
  output logic                             fs_from_register,
  output logic      [7:0]                  full_scale_code,
  output logic                             diff_reset_mode,
  output logic                             out_clock_reset_neg,
  output logic                             cal_delay_select,
  output logic                             des_mode,
  output logic                             serial_chip_select
);
  import strap_decode_pkg::*;

  function automatic level_e decode_level(input pad_code_t code);
    unique case (code)
      PAD_LOW:  decode_level = LVL_LOW;
      PAD_HIGH: decode_level = LVL_HIGH;
      // An illegal comparator code is taken as mid, the floating case.
      default:  decode_level = LVL_MID;
    endcase
  endfunction : decode_level

  strap_pins_s   pins_s1_q;
  strap_pins_s   pins_s2_q;
  logic          clk_s1_q;
  logic          clk_s2_q;
  logic          clk_s3_q;
  logic          clk_fall;
  strap_levels_s levels_q;
  logic          sample_strobe_q;

  // Pins are asynchronous to clk; two flops before any logic looks at them.
  always_ff @(posedge clk) begin
    if (rst) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
      clk_s1_q  <= 1'b0;
      clk_s2_q  <= 1'b0;
      clk_s3_q  <= 1'b0;
    end else begin
      pins_s1_q <= straps;
      pins_s2_q <= pins_s1_q;
      clk_s1_q  <= input_clk_p;
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
    end
  end

  assign clk_fall = clk_s3_q & ~clk_s2_q;

  // Strap levels are only taken at a falling edge of the input clock and held in flops,
  // so a pin that moves mid-cycle cannot glitch any mode.
  always_ff @(posedge clk) begin
    if (rst) begin
      levels_q        <= LEVELS_RESET;
      sample_strobe_q <= 1'b0;
    end else begin
      sample_strobe_q <= clk_fall;
      if (clk_fall) begin
        levels_q.shared_pin                <= decode_level(pins_s2_q.shared_pin);
        levels_q.dedicated_ext_ctrl_enable <= decode_level(pins_s2_q.dedicated_ext_ctrl_enable);
        levels_q.reset_signaling_select    <= decode_level(pins_s2_q.reset_signaling_select);
        levels_q.cal_pin                   <= decode_level(pins_s2_q.cal_pin);
      end
    end
  end

  logic [FS_W-1:0] fs_adjust_q;
  ctrl_mode_e      mode_d;
  logic            diff_d;
  logic            fs_high_d;
  logic            reset_neg_d;
  logic            cal_delay_d;
  logic            des_d;
  logic            chip_select_d;
  logic [FS_W-1:0] fs_code_d;

  always_comb begin
    diff_d = (levels_q.reset_signaling_select == LVL_LOW);
    unique case (levels_q.dedicated_ext_ctrl_enable)
      LVL_LOW:  mode_d = MODE_EXT;
      LVL_HIGH: mode_d = MODE_PIN;
      default: begin
        // The shared pin only acts as an enable while reset signalling is single-ended.
        if (!diff_d && levels_q.shared_pin == LVL_MID) begin
          mode_d = MODE_EXT;
        end else begin
          mode_d = MODE_PIN;
        end
      end
    endcase
    if (diff_d) begin
      fs_high_d = 1'b1;
    end else begin
      fs_high_d = (levels_q.shared_pin == LVL_HIGH);
    end
    reset_neg_d = diff_d && (levels_q.shared_pin == LVL_HIGH);
    if (mode_d == MODE_EXT) begin
      cal_delay_d   = CAL_DELAY_SHORT;
      des_d         = 1'b0;
      chip_select_d = (levels_q.cal_pin == LVL_HIGH);
      fs_code_d     = fs_adjust_q;
    end else begin
      cal_delay_d   = (levels_q.cal_pin == LVL_HIGH);
      des_d         = (levels_q.cal_pin == LVL_MID);
      chip_select_d = 1'b0;
      fs_code_d     = fs_high_d ? FS_CODE_HIGH : FS_CODE_LOW;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      full_scale_high     <= 1'b1;
      full_scale_code     <= FS_CODE_HIGH;
      diff_reset_mode     <= 1'b0;
      out_clock_reset_neg <= 1'b0;
      cal_delay_select    <= CAL_DELAY_SHORT;
      des_mode            <= 1'b0;
      serial_chip_select  <= 1'b0;
    end else begin
      full_scale_high     <= fs_high_d;
      full_scale_code     <= fs_code_d;
      diff_reset_mode     <= diff_d;
      out_clock_reset_neg <= reset_neg_d;
      cal_delay_select    <= cal_delay_d;
      des_mode            <= des_d;
      serial_chip_select  <= chip_select_d;
    end
  end

  // Two flops of one state, so both outputs stay straight from flip-flops.
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_mode         <= 1'b0;
      fs_from_register <= 1'b0;
    end else begin
      ext_mode         <= (mode_d == MODE_EXT);
      fs_from_register <= (mode_d == MODE_EXT);
    end
  end

  assign sample_strobe = sample_strobe_q;

  // AHB-Lite slave with zero wait states; read data is prepared at the address edge.
  logic        addr_taken;
  logic        wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign addr_taken = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_comb begin
    status_word                                     = '0;
    status_word[ST_EXT_MODE]                        = ext_mode;
    status_word[ST_FS_HIGH]                         = full_scale_high;
    status_word[ST_FS_FROM_REG]                     = fs_from_register;
    status_word[ST_DIFF_RESET]                      = diff_reset_mode;
    status_word[ST_RESET_NEG]                       = out_clock_reset_neg;
    status_word[ST_CAL_DELAY]                       = cal_delay_select;
    status_word[ST_DES]                             = des_mode;
    status_word[ST_CHIP_SELECT]                     = serial_chip_select;
    status_word[ST_FS_CODE_LSB +: FS_W]             = full_scale_code;
    rd_mux = '0;
    if (haddr[31:ADDR_LSB] == ADDR_FS_ADJUST[31:ADDR_LSB]) begin
      rd_mux[FS_W-1:0] = fs_adjust_q;
    end else if (haddr[31:ADDR_LSB] == ADDR_STATUS[31:ADDR_LSB]) begin
      rd_mux = status_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata    <= '0;
    end else begin
      wr_pend_q <= addr_taken && hwrite;
      if (addr_taken) begin
        wr_addr_q <= haddr;
      end
      if (addr_taken && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Writes to the status word or unmapped space are dropped; only the adjust value stores.
  always_ff @(posedge clk) begin
    if (rst) begin
      fs_adjust_q <= FS_ADJUST_RESET;
    end else if (wr_pend_q && wr_addr_q[31:ADDR_LSB] == ADDR_FS_ADJUST[31:ADDR_LSB]) begin
      fs_adjust_q <= hwdata[FS_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  AST_SAMPLE_EDGE: assert property (@(posedge clk) disable iff (rst)
    sample_strobe_q |-> $past(clk_s3_q) && !$past(clk_s2_q))
    else $error("Sample strobe without a falling input clock edge.");

  AST_LEVEL_HOLD: assert property (@(posedge clk) disable iff (rst)
    !clk_fall |=> $stable(levels_q))
    else $error("Strap levels changed without a sampling edge.");

  AST_DED_PRIORITY: assert property (@(posedge clk) disable iff (rst)
    levels_q.dedicated_ext_ctrl_enable == LVL_LOW |=> ext_mode)
    else $error("Dedicated enable low did not select extended mode.");

  AST_DED_HIGH: assert property (@(posedge clk) disable iff (rst)
    levels_q.dedicated_ext_ctrl_enable == LVL_HIGH |=> !ext_mode && !serial_chip_select)
    else $error("Dedicated enable high left extended mode active.");

  AST_ALT_ENABLE: assert property (@(posedge clk) disable iff (rst)
    levels_q.dedicated_ext_ctrl_enable == LVL_MID && levels_q.shared_pin == LVL_MID
    && levels_q.reset_signaling_select != LVL_LOW |=> ext_mode && fs_from_register)
    else $error("Floating shared pin did not enable extended mode.");

  AST_RANGE_SEL: assert property (@(posedge clk) disable iff (rst)
    levels_q.reset_signaling_select != LVL_LOW && levels_q.shared_pin == LVL_LOW
    |=> !full_scale_high && (ext_mode || full_scale_code == FS_CODE_LOW))
    else $error("Low range select did not give the reduced range.");

  AST_DIFF_RANGE: assert property (@(posedge clk) disable iff (rst)
    levels_q.reset_signaling_select == LVL_LOW
    |=> diff_reset_mode && full_scale_high && (ext_mode || full_scale_code == FS_CODE_HIGH))
    else $error("Differential reset mode did not force the higher range.");

  AST_RESET_NEG: assert property (@(posedge clk) disable iff (rst)
    out_clock_reset_neg |-> diff_reset_mode && $past(levels_q.shared_pin) == LVL_HIGH)
    else $error("Negative reset leg driven outside differential mode.");

  AST_EXT_CAL: assert property (@(posedge clk) disable iff (rst)
    ext_mode |-> cal_delay_select == CAL_DELAY_SHORT && !des_mode)
    else $error("Calibration delay not forced short in extended mode.");

  AST_DES: assert property (@(posedge clk) disable iff (rst)
    des_mode |-> !ext_mode && $past(levels_q.cal_pin) == LVL_MID)
    else $error("Dual-edge sampling without a mid calibration pin.");

  AST_CHIP_SEL: assert property (@(posedge clk) disable iff (rst)
    serial_chip_select |-> ext_mode && $past(levels_q.cal_pin) == LVL_HIGH)
    else $error("Chip select active outside extended mode.");

  AST_CAL_PIN: assert property (@(posedge clk) disable iff (rst)
    levels_q.dedicated_ext_ctrl_enable == LVL_HIGH && levels_q.cal_pin == LVL_HIGH
    |=> cal_delay_select && !des_mode)
    else $error("Calibration pin high did not select the delay in pin mode.");

  AST_DIFF_NO_ALT: assert property (@(posedge clk) disable iff (rst)
    levels_q.reset_signaling_select == LVL_LOW && levels_q.dedicated_ext_ctrl_enable == LVL_MID
    |=> !ext_mode && out_clock_reset_neg == ($past(levels_q.shared_pin) == LVL_HIGH))
    else $error("Shared pin acted as an enable in differential reset mode.");

  AST_FS_REG: assert property (@(posedge clk) disable iff (rst)
    ext_mode && $stable(fs_adjust_q) |=> !ext_mode || full_scale_code == $past(fs_adjust_q))
    else $error("Extended mode range not taken from the adjust register.");

endmodule : adc_control_pin_mode_decode

`default_nettype wire

// [sim/strap_board_model.sv]
// Board model that drives the control straps and a free-running converter input clock.
`timescale 1ns/1ps
`default_nettype none

module strap_board_model #(
  parameter int HALF_PERIOD = 8
) (
  input  wire logic                         clk,
  input  wire strap_decode_pkg::strap_pins_s pins_req,
  output logic                              input_clk_p,
  output strap_decode_pkg::strap_pins_s      straps
);
  import strap_decode_pkg::*;

  int          count_q = 0;
  logic        phase_q = 1'b0;
  strap_pins_s straps_q = '{PAD_MID, PAD_MID, PAD_MID, PAD_MID};

  // The input clock runs free, as a sampling clock does, so the decoder sees falls at all times.
  always_ff @(posedge clk) begin
    if (count_q == HALF_PERIOD - 1) begin
      count_q <= 0;
      phase_q <= ~phase_q;
    end else begin
      count_q <= count_q + 1;
    end
  end

  // Straps move whenever the board asks, with no regard to the input clock phase.
  always_ff @(posedge clk) begin
    straps_q <= pins_req;
  end

  assign input_clk_p = phase_q;
  assign straps      = straps_q;

endmodule : strap_board_model

`default_nettype wire

// [sim/tb.sv]
// Self-checking testbench for the control strap mode decoder.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import strap_decode_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire  [1:0]  hresp;
  wire         input_clk_p;
  wire         sample_strobe;
  wire  [15:0] outv;
  strap_pins_s pins_req = '{PAD_MID, PAD_MID, PAD_MID, PAD_MID};
  strap_pins_s straps;
  int          bad_count = 0;
  int          num_checks = 0;
  logic [31:0] rd;

  always #2 clk = ~clk;

  strap_board_model strap_board_model_i (.clk(clk), .pins_req(pins_req),
    .input_clk_p(input_clk_p), .straps(straps));

  adc_control_pin_mode_decode adc_control_pin_mode_decode_i (
    .clk(clk), .rst(rst), .input_clk_p(input_clk_p), .straps(straps),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_strobe(sample_strobe), .ext_mode(outv[ST_EXT_MODE]),
    .full_scale_high(outv[ST_FS_HIGH]), .fs_from_register(outv[ST_FS_FROM_REG]),
    .full_scale_code(outv[15:8]), .diff_reset_mode(outv[ST_DIFF_RESET]),
    .out_clock_reset_neg(outv[ST_RESET_NEG]), .cal_delay_select(outv[ST_CAL_DELAY]),
    .des_mode(outv[ST_DES]), .serial_chip_select(outv[ST_CHIP_SELECT]));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Called just after a rising edge; returns at the edge that ends the data phase.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdata);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
    check({30'h0, hresp}, {30'h0, HRESP_OKAY});
  endtask : ahb

  function automatic pad_code_t pad(input int l);
    return (l == 0) ? PAD_LOW : (l == 1) ? PAD_MID : PAD_HIGH;
  endfunction : pad

  // Levels are 0 low, 1 mid or floating, 2 high.
  function automatic logic [31:0] expect_st(input int sh, de, rs, ca, input logic [7:0] adj);
    logic        diff;
    logic        ext;
    logic        fsh;
    logic [31:0] r;
    diff = (rs == 0);
    ext  = (de == 0) || (de == 1 && !diff && sh == 1);
    fsh  = diff || (sh == 2);
    r = '0;
    r[ST_EXT_MODE]    = ext;
    r[ST_FS_HIGH]     = fsh;
    r[ST_FS_FROM_REG] = ext;
    r[ST_DIFF_RESET]  = diff;
    r[ST_RESET_NEG]   = diff && (sh == 2);
    r[ST_CAL_DELAY]   = !ext && (ca == 2);
    r[ST_DES]         = !ext && (ca == 1);
    r[ST_CHIP_SELECT] = ext && (ca == 2);
    r[ST_FS_CODE_LSB +: FS_W] = ext ? adj : (fsh ? FS_CODE_HIGH : FS_CODE_LOW);
    return r;
  endfunction : expect_st

  task automatic wait_strobe;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sample_strobe !== 1'b1 && n < 64);
    check({31'h0, sample_strobe}, 32'h1);
    // Outputs follow the latched levels one clock after the strobe.
    @(negedge clk);
  endtask : wait_strobe

  task automatic apply(input int sh, de, rs, ca, input logic [7:0] adj);
    @(posedge clk);
    pins_req <= '{pad(sh), pad(de), pad(rs), pad(ca)};
    wait_strobe();
    wait_strobe();
    check({16'h0, outv}, expect_st(sh, de, rs, ca, adj));
    @(posedge clk);
    ahb(1'b0, ADDR_STATUS, '0, rd);
    check(rd, expect_st(sh, de, rs, ca, adj));
  endtask : apply

  task automatic t_regs;
    ahb(1'b0, ADDR_FS_ADJUST, '0, rd);
    check(rd, {24'h0, FS_ADJUST_RESET});
    ahb(1'b1, ADDR_FS_ADJUST, 32'hFFFF_FF5A, rd);
    ahb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF, rd);
    ahb(1'b0, ADDR_FS_ADJUST, '0, rd);
    check(rd, 32'h0000_005A);
    ahb(1'b0, 32'h0000_0008, '0, rd);
    check(rd, 32'h0);
    $display("test regs done");
  endtask : t_regs

  // Every combination of the four three-level straps.
  task automatic t_table;
    for (int sh = 0; sh < 3; sh++) begin
      for (int de = 0; de < 3; de++) begin
        for (int rs = 0; rs < 3; rs++) begin
          for (int ca = 0; ca < 3; ca++) begin
            apply(sh, de, rs, ca, 8'h5A);
          end
        end
      end
    end
    $display("test table done");
  endtask : t_table

  // A short pin excursion between two falls must leave the modes alone.
  task automatic t_glitch;
    apply(2, 2, 2, 2, 8'h5A);
    wait_strobe();
    @(posedge clk);
    pins_req <= '{PAD_LOW, PAD_LOW, PAD_LOW, 2'h2};
    repeat (3) @(posedge clk);
    pins_req <= '{PAD_HIGH, PAD_HIGH, PAD_HIGH, PAD_HIGH};
    repeat (4) @(negedge clk);
    check({16'h0, outv}, expect_st(2, 2, 2, 2, 8'h5A));
    wait_strobe();
    wait_strobe();
    check({16'h0, outv}, expect_st(2, 2, 2, 2, 8'h5A));
    @(posedge clk);
    pins_req <= '{PAD_HIGH, PAD_HIGH, PAD_HIGH, 2'h2};
    wait_strobe();
    wait_strobe();
    check({16'h0, outv}, expect_st(2, 2, 2, 1, 8'h5A));
    $display("test glitch done");
  endtask : t_glitch

  // Strobes follow falls of the input clock only, one cycle each.
  task automatic t_strobe;
    int n;
    do @(negedge clk); while (input_clk_p !== 1'b1);
    for (int k = 0; k < 4; k++) begin
      do @(negedge clk); while (input_clk_p !== 1'b0);
      n = 0;
      repeat (7) begin
        @(negedge clk);
        n += (sample_strobe === 1'b1);
      end
      check(n, 1);
      do @(negedge clk); while (input_clk_p !== 1'b1);
      n = 0;
      repeat (7) begin
        @(negedge clk);
        n += (sample_strobe === 1'b1);
      end
      check(n, 0);
    end
    $display("test strobe done");
  endtask : t_strobe

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_table();
    t_glitch();
    t_strobe();
    end_of_test();
  end

  // The whole table takes about 2600 cycles; this limit leaves a wide margin.
  initial begin
    #80000;
    bad_count++;
    end_of_test();
  end

endmodule : tb

`default_nettype wire
